/* File: design/ccache_pkg.sv */
// Constants for the split instruction/data cache.
// Shared by the cache top level and the verification side.
package ccache_pkg;
   // Register offsets on the plain register port
   localparam logic [7:0] REG_CTRL  = 8'h00;
   localparam logic [7:0] REG_ENTRY = 8'h04;
   localparam logic [7:0] REG_STAT  = 8'h08;
   // Control register bit positions
   localparam int CTL_IEN  = 0;
   localparam int CTL_ICLR = 1;
   localparam int CTL_IENT = 2;
   localparam int CTL_DEN  = 3;
   localparam int CTL_DCLR = 4;
   localparam int CTL_DENT = 5;
   localparam int CTL_WA   = 6;
   // Status register bit positions
   localparam int STA_BUSY = 0;
   localparam int STA_DIS  = 1;
   // Geometry and address fields
   localparam int LINES    = 16;
   localparam int WORDS    = 4;
   localparam int TAG_W    = 24;
   localparam int TAG_LSB  = 8;
   localparam int LINE_LSB = 4;
   localparam int ENT_LSB  = 2;
   // Cache select index
   localparam logic CI = 1'b0;
   localparam logic CD = 1'b1;
   // Entry register reset value and remaining-word count less one loaded at burst start
   localparam logic [31:0] ENTRY_RST = 32'h0000_0000;
   localparam logic [1:0]  BURST_LEFT = 2'h2;

   typedef enum logic [1:0] {S_IDLE, S_BUS, S_BURST} ccache_state_type;
endpackage

/* File: design/ccache_top.sv */
// Split direct-mapped instruction and data caches with burst line fill.
// Assumes a core that holds its request until the one-cycle acknowledge
// and drops it in the following cycle, and an external bus controller
// whose termination, acknowledge, error and data pins are asynchronous.
//
// Function
// - Instruction cache: sixteen lines, four words
// - Word entries selected individually by address
// - Instruction tag: 24 bits, supervisor bit, valids
// - Instruction miss triggers burst line fill
// - Control register clears cache or entry
// - Cleared enable stops lookups and fills
// - Disable input stops both caches anytime
// - Data tag holds all function code bits
// - Data write hit updates cache and bus
// - Write miss: bus write, allocate if enabled
// - Burst only requested, continues per termination
// - Burst ends: line done, error, inhibit, unacked
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module ccache_top (
   // Clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        sys_rst_i,
   // Register port
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   // Core access port
   input  wire logic        core_req_i,
   input  wire logic        core_instr_i,
   input  wire logic        core_we_i,
   input  wire logic [31:0] core_addr_i,
   input  wire logic [2:0]  core_fc_i,
   input  wire logic [31:0] core_wdata_i,
   output logic             core_ack_o,
   output logic             core_err_o,
   output logic      [31:0] core_rdata_o,
   // External bus controller
   output logic             bus_req_o,
   output logic             bus_we_o,
   output logic      [31:0] bus_addr_o,
   output logic      [2:0]  bus_fc_o,
   output logic      [31:0] bus_wdata_o,
   output logic             burst_request_output_o,
   input  wire logic [31:0] bus_rdata_i,
   input  wire logic        synchronous_termination_input_i,
   input  wire logic        burst_acknowledge_input_i,
   input  wire logic        bus_error_input_i,
   input  wire logic        cache_inhibit_input_i,
   input  wire logic        cache_disable_input_i
);

   typedef struct packed {
      ccache_pkg::ccache_state_type st;
      // Control register state
      logic        ien;
      logic        den;
      logic        wa;
      logic [31:0] ent_addr;
      logic [31:0] rdata;
      // Two-stage synchronisers, first stage feeds only the second
      logic [1:0]  dis_sy;
      logic [1:0]  term_sy;
      logic [1:0]  back_sy;
      logic [1:0]  err_sy;
      logic [1:0]  inh_sy;
      logic [31:0] dat_m;
      logic [31:0] dat_s;
      // Cache arrays, index 0 instruction, 1 data
      logic [1:0][ccache_pkg::LINES-1:0][ccache_pkg::WORDS-1:0][31:0] data;
      logic [1:0][ccache_pkg::LINES-1:0][ccache_pkg::TAG_W-1:0]       tag;
      logic [1:0][ccache_pkg::LINES-1:0][2:0]                         fc;
      logic [1:0][ccache_pkg::LINES-1:0][ccache_pkg::WORDS-1:0]       valid;
      // Bus transaction
      logic        csel;
      logic        fill_ok;
      logic        breq;
      logic        bus_req;
      logic        bus_we;
      logic [31:0] baddr;
      logic [2:0]  bfc;
      logic [31:0] bwdata;
      logic [1:0]  ent;
      logic [1:0]  left;
      // Core answer
      logic        ack;
      logic        err;
      logic [31:0] crdata;
   } ccache_regs_type;

   ccache_regs_type r;
   ccache_regs_type next_r;

   // Function code as stored: instruction side keeps only the supervisor bit
   function automatic logic [2:0] fc_key(input logic c, input logic [2:0] fc);
      fc_key = (c == ccache_pkg::CD) ? fc : {fc[2], 2'b00};
   endfunction

   // Lookup in one cache; tag, address space and entry valid must all agree
   function automatic logic hit_of(input ccache_regs_type s, input logic c,
                                   input logic [31:0] a, input logic [2:0] fc);
      logic [3:0] ln;
      logic [1:0] en;
      ln = a[ccache_pkg::LINE_LSB +: 4];
      en = a[ccache_pkg::ENT_LSB +: 2];
      hit_of = s.valid[c][ln][en]
               && (s.tag[c][ln] == a[ccache_pkg::TAG_LSB +: ccache_pkg::TAG_W])
               && (s.fc[c][ln] == fc_key(c, fc));
   endfunction

   // Store one word; a new tag replaces the line and drops its old valids
   function automatic ccache_regs_type store(input ccache_regs_type s, input logic c,
                                             input logic [31:0] a, input logic [1:0] en,
                                             input logic [2:0] fc,
                                             input logic [31:0] w);
      ccache_regs_type t;
      logic [3:0]      ln;
      t = s;
      ln = a[ccache_pkg::LINE_LSB +: 4];
      if ((t.tag[c][ln] != a[ccache_pkg::TAG_LSB +: ccache_pkg::TAG_W])
          || (t.fc[c][ln] != fc_key(c, fc))) begin
         t.valid[c][ln] = 4'h0;
         t.tag[c][ln]   = a[ccache_pkg::TAG_LSB +: ccache_pkg::TAG_W];
         t.fc[c][ln]    = fc_key(c, fc);
      end
      t.data[c][ln][en]  = w;
      t.valid[c][ln][en] = 1'b1;
      store = t;
   endfunction

   logic       use_i;
   logic       use_d;
   logic       use_c;
   logic       c_sel;
   logic [1:0] c_ent;
   logic [3:0] e_ln;
   logic [1:0] e_en;

   // Next-state logic for registers, synchronisers and the access sequence
   always_comb begin
      next_r = r;
      next_r.ack = 1'b0;
      next_r.err = 1'b0;
      next_r.rdata = 32'h0000_0000;
      // Synchroniser shifts
      next_r.dis_sy  = {r.dis_sy[0], cache_disable_input_i};
      next_r.term_sy = {r.term_sy[0], synchronous_termination_input_i};
      next_r.back_sy = {r.back_sy[0], burst_acknowledge_input_i};
      next_r.err_sy  = {r.err_sy[0], bus_error_input_i};
      next_r.inh_sy  = {r.inh_sy[0], cache_inhibit_input_i};
      next_r.dat_m   = bus_rdata_i;
      next_r.dat_s   = r.dat_m;
      // A cache is usable only if enabled and not held off by hardware
      use_i = r.ien && !r.dis_sy[1];
      use_d = r.den && !r.dis_sy[1];
      c_sel = core_instr_i ? ccache_pkg::CI : ccache_pkg::CD;
      use_c = core_instr_i ? use_i : use_d;
      c_ent = core_addr_i[ccache_pkg::ENT_LSB +: 2];
      e_ln  = r.ent_addr[ccache_pkg::LINE_LSB +: 4];
      e_en  = r.ent_addr[ccache_pkg::ENT_LSB +: 2];

      // Register reads answer one cycle later; unmapped reads return zero
      if (reg_rd_i) begin
         case (reg_addr_i)
            ccache_pkg::REG_CTRL: begin
               next_r.rdata[ccache_pkg::CTL_IEN] = r.ien;
               next_r.rdata[ccache_pkg::CTL_DEN] = r.den;
               next_r.rdata[ccache_pkg::CTL_WA]  = r.wa;
            end
            ccache_pkg::REG_ENTRY: next_r.rdata = r.ent_addr;
            ccache_pkg::REG_STAT: begin
               next_r.rdata[ccache_pkg::STA_BUSY] = (r.st != ccache_pkg::S_IDLE);
               next_r.rdata[ccache_pkg::STA_DIS]  = r.dis_sy[1];
            end
            default: next_r.rdata = 32'h0000_0000;
         endcase
      end

      // Register writes; clear bits act once and read back as zero.
      // Applied before the sequence so a fill in the same cycle still sets.
      if (reg_wr_i) begin
         case (reg_addr_i)
            ccache_pkg::REG_CTRL: begin
               next_r.ien = reg_wdata_i[ccache_pkg::CTL_IEN];
               next_r.den = reg_wdata_i[ccache_pkg::CTL_DEN];
               next_r.wa  = reg_wdata_i[ccache_pkg::CTL_WA];
               if (reg_wdata_i[ccache_pkg::CTL_ICLR]) begin
                  next_r.valid[ccache_pkg::CI] = '0;
               end
               if (reg_wdata_i[ccache_pkg::CTL_DCLR]) begin
                  next_r.valid[ccache_pkg::CD] = '0;
               end
               if (reg_wdata_i[ccache_pkg::CTL_IENT]) begin
                  next_r.valid[ccache_pkg::CI][e_ln][e_en] = 1'b0;
               end
               if (reg_wdata_i[ccache_pkg::CTL_DENT]) begin
                  next_r.valid[ccache_pkg::CD][e_ln][e_en] = 1'b0;
               end
            end
            ccache_pkg::REG_ENTRY: next_r.ent_addr = reg_wdata_i;
            default: ;
         endcase
      end

      case (r.st)
         ccache_pkg::S_IDLE: begin
            // Ack still high means the core has not yet dropped its request
            if (core_req_i && !r.ack) begin
               if (!core_we_i && use_c
                   && hit_of(r, c_sel, core_addr_i, core_fc_i)) begin
                  next_r.ack = 1'b1;
                  next_r.crdata = r.data[c_sel][core_addr_i[ccache_pkg::LINE_LSB +: 4]][c_ent];
               end else begin
                  next_r.st      = ccache_pkg::S_BUS;
                  next_r.csel    = c_sel;
                  next_r.fill_ok = use_c;
                  next_r.bus_req = 1'b1;
                  next_r.bus_we  = core_we_i;
                  next_r.breq    = use_c && !core_we_i;
                  next_r.baddr   = core_addr_i;
                  next_r.bfc     = core_fc_i;
                  next_r.bwdata  = core_wdata_i;
                  next_r.ent     = c_ent;
               end
            end
         end
         ccache_pkg::S_BUS: begin
            if (r.term_sy[1]) begin
               next_r.breq = 1'b0;
               if (r.err_sy[1]) begin
                  next_r.bus_req = 1'b0;
                  next_r.err = 1'b1;
                  next_r.ack = 1'b1;
                  next_r.st = ccache_pkg::S_IDLE;
               end else if (r.bus_we) begin
                  // Write-through: the external write has completed
                  if (use_d && (hit_of(r, ccache_pkg::CD, r.baddr, r.bfc) || r.wa)) begin
                     next_r = store(next_r, ccache_pkg::CD, r.baddr, r.ent, r.bfc,
                                    r.bwdata);
                  end
                  next_r.bus_req = 1'b0;
                  next_r.ack = 1'b1;
                  next_r.st = ccache_pkg::S_IDLE;
               end else begin
                  next_r.crdata = r.dat_s;
                  if (r.fill_ok && !r.inh_sy[1] && (r.csel ? use_d : use_i)) begin
                     next_r = store(next_r, r.csel, r.baddr, r.ent, r.bfc,
                                    r.dat_s);
                  end
                  next_r.ack = 1'b1;
                  // Burst continues only after a requested, acknowledged first cycle
                  if (r.breq && r.back_sy[1] && !r.inh_sy[1]) begin
                     next_r.st   = ccache_pkg::S_BURST;
                     next_r.ent  = r.ent + 2'd1;
                     next_r.left = ccache_pkg::BURST_LEFT;
                  end else begin
                     next_r.bus_req = 1'b0;
                     next_r.st = ccache_pkg::S_IDLE;
                  end
               end
            end
         end
         ccache_pkg::S_BURST: begin
            // Core already has its word; remaining entries stream in
            if (r.err_sy[1] || r.inh_sy[1] || !r.back_sy[1]) begin
               next_r.bus_req = 1'b0;
               next_r.st = ccache_pkg::S_IDLE;
            end else if (r.term_sy[1]) begin
               if (r.csel ? use_d : use_i) begin
                  next_r = store(next_r, r.csel, r.baddr, r.ent, r.bfc,
                                 r.dat_s);
               end
               next_r.ent  = r.ent + 2'd1;
               next_r.left = r.left - 2'd1;
               if (r.left == 2'd0) begin
                  next_r.bus_req = 1'b0;
                  next_r.st = ccache_pkg::S_IDLE;
               end
            end
         end
         default: begin
            next_r.st = ccache_pkg::S_IDLE;
            next_r.bus_req = 1'b0;
            next_r.breq = 1'b0;
         end
      endcase
   end

   // State register; all control state resets to constants
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         r <= '0;
         r.st <= ccache_pkg::S_IDLE;
         r.ent_addr <= ccache_pkg::ENTRY_RST;
      end else begin
         r <= next_r;
      end
   end

   // Outputs straight from the state register
   assign reg_rdata_o            = r.rdata;
   assign core_ack_o             = r.ack;
   assign core_err_o             = r.err;
   assign core_rdata_o           = r.crdata;
   assign bus_req_o              = r.bus_req;
   assign bus_we_o               = r.bus_we;
   assign bus_addr_o             = r.baddr;
   assign bus_fc_o               = r.bfc;
   assign bus_wdata_o            = r.bwdata;
   assign burst_request_output_o = r.breq;

endmodule

/* File: verif/ccache_top_asserts.sv */
// Port-level assertions for the split cache top level.
// Assumes the core and bus partner keep the hand-over timing.
`timescale 1ns/1ps
module ccache_top_asserts (
   // Clock and reset
   input wire logic        ref_clk_i,
   input wire logic        sys_rst_i,
   // Register port
   input wire logic [7:0]  reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic        reg_wr_i,
   input wire logic        reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   // Core port
   input wire logic        core_instr_i,
   input wire logic        core_we_i,
   input wire logic [31:0] core_addr_i,
   input wire logic [31:0] core_wdata_i,
   input wire logic        core_ack_o,
   input wire logic        core_err_o,
   // Bus side
   input wire logic        bus_req_o,
   input wire logic        bus_we_o,
   input wire logic [31:0] bus_addr_o,
   input wire logic [2:0]  bus_fc_o,
   input wire logic [31:0] bus_wdata_o,
   input wire logic        burst_request_output_o,
   input wire logic        synchronous_termination_input_i,
   input wire logic        cache_disable_input_i
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);
   logic       seen_bus;
   logic       seen_wr;
   logic [1:0] en;
   logic [2:0] dis_cnt;
   logic [2:0] term_cnt;
   // Bus activity since the last ack, enables as written, disable age, terminations per cycle
   always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         seen_bus <= 1'b0;
         seen_wr  <= 1'b0;
         en       <= 2'h0;
         dis_cnt  <= 3'h0;
         term_cnt <= 3'h0;
      end else begin
         seen_bus <= !core_ack_o && (seen_bus || bus_req_o);
         seen_wr  <= !core_ack_o && (seen_wr || (bus_req_o && bus_we_o));
         if (reg_wr_i && reg_addr_i == ccache_pkg::REG_CTRL)
            en <= {reg_wdata_i[ccache_pkg::CTL_DEN], reg_wdata_i[ccache_pkg::CTL_IEN]};
         dis_cnt  <= !cache_disable_input_i ? 3'h0 : dis_cnt + {2'h0, dis_cnt != 3'h7};
         term_cnt <= !bus_req_o ? 3'h0 : term_cnt + {2'h0, synchronous_termination_input_i};
      end
   end
   AST_RDATA_ZERO: assert property (!$past(reg_rd_i) || !($past(reg_addr_i) inside {8'h00, 8'h04, 8'h08}) |-> reg_rdata_o == 32'h0)
      else $error("register read data outside its slot");
   AST_ENABLE_OFF: assert property (core_ack_o && !(core_instr_i ? en[0] : en[1]) |-> seen_bus)
      else $error("ack from a disabled cache without bus cycle");
   AST_DISABLE_PIN: assert property (core_ack_o && dis_cnt >= 3'h6 |-> seen_bus)
      else $error("ack under cache disable without bus cycle");
   AST_WRITE_DATA: assert property ($rose(bus_req_o) && bus_we_o |-> bus_wdata_o == core_wdata_i && bus_addr_o == core_addr_i)
      else $error("bus write does not carry core data");
   AST_WRITE_OUT: assert property (core_ack_o && core_we_i |-> seen_wr)
      else $error("write acknowledged without external write");
   AST_BURST_READ: assert property (burst_request_output_o |-> bus_req_o && !bus_we_o)
      else $error("burst request outside a read cycle");
   AST_BUS_STABLE: assert property (bus_req_o && $past(bus_req_o) |-> $stable(bus_addr_o) && $stable(bus_fc_o) && $stable(bus_we_o))
      else $error("bus qualifiers moved during cycle");
   AST_ACK_WAIT: assert property ($rose(bus_req_o) |-> !core_ack_o [*3])
      else $error("ack before termination could arrive");
   AST_BURST_DROP: assert property (burst_request_output_o && synchronous_termination_input_i |-> ##[1:3] !burst_request_output_o)
      else $error("burst request held after first termination");
   AST_BUS_END: assert property ($fell(bus_req_o) |-> term_cnt != 3'h0)
      else $error("bus cycle ended without termination");
   AST_ERR_ACK: assert property (core_err_o |-> core_ack_o)
      else $error("error without ack");
   // Main scenarios reached
   cover property (burst_request_output_o && synchronous_termination_input_i);
   cover property (core_err_o);
   cover property (core_ack_o && core_we_i && seen_wr);
endmodule
bind ccache_top ccache_top_asserts u_asserts (.*);

/* File: verif/ccache_bus_model.sv */
// Bus controller model: terminates cycles, bursts, errors, inhibits.
// Assumes the cache passes these pins through two flops.
`timescale 1ns/1ps
module ccache_bus_model (
   // Clock
   input  wire logic        ref_clk_i,
   // Cache bus outputs
   input  wire logic        bus_req_o,
   input  wire logic [31:0] bus_addr_o,
   input  wire logic        burst_request_output_o,
   // Answers to the cache
   output logic      [31:0] bus_rdata_i,
   output logic             synchronous_termination_input_i,
   output logic             burst_acknowledge_input_i,
   output logic             bus_error_input_i,
   output logic             cache_inhibit_input_i,
   // Scenario controls
   input  wire logic        burst_en,
   input  wire logic        err_en,
   input  wire logic        inh_en
);
   logic [1:0] cnt;
   logic       done;
   initial {bus_rdata_i, synchronous_termination_input_i, burst_acknowledge_input_i,
            bus_error_input_i, cache_inhibit_input_i, cnt, done} = '0;
   // First word a cycle after the request, burst words back to back
   always @(posedge ref_clk_i) begin
      synchronous_termination_input_i <= 1'b0;
      bus_error_input_i               <= 1'b0;
      cache_inhibit_input_i           <= 1'b0;
      bus_rdata_i                     <= ~bus_rdata_i;  // Released data never looks stale
      if (!bus_req_o) begin
         cnt                       <= 2'h0;
         done                      <= 1'b0;
         burst_acknowledge_input_i <= 1'b0;
      end else if (!done) begin
         synchronous_termination_input_i <= 1'b1;
         bus_error_input_i               <= err_en;
         cache_inhibit_input_i           <= inh_en;
         bus_rdata_i <= {bus_addr_o[31:4], bus_addr_o[3:2] + cnt, 2'b00} ^ 32'hc0de_0000;
         cnt         <= cnt + 2'h1;
         if (cnt == 2'h0)
            burst_acknowledge_input_i <= burst_en && burst_request_output_o;
         done <= cnt == 2'h3 || err_en || inh_en || !burst_en
                 || (cnt == 2'h0 && !burst_request_output_o);
      end
   end
endmodule

/* File: verif/tb_ccache_top.sv */
// Self-checking bench for the split cache top level.
// Assumes the bus model answers every bus cycle.
`timescale 1ns/1ps
module tb_ccache_top;
   localparam logic [31:0] EN = (32'h1 << ccache_pkg::CTL_IEN) | (32'h1 << ccache_pkg::CTL_DEN);
   logic        ref_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, core_req_i, core_instr_i, core_we_i;
   logic        core_ack_o, core_err_o, bus_req_o, bus_we_o, burst_request_output_o, bus_q;
   logic        synchronous_termination_input_i, burst_acknowledge_input_i, bus_error_input_i;
   logic        cache_inhibit_input_i, cache_disable_input_i, burst_en, err_en, inh_en;
   logic [7:0]  reg_addr_i;
   logic [2:0]  core_fc_i, bus_fc_o;
   logic [31:0] reg_wdata_i, reg_rdata_o, core_addr_i, core_wdata_i, core_rdata_o;
   logic [31:0] bus_addr_o, bus_wdata_o, bus_rdata_i;
   int          miscompares, total_checks, nbus, cycles;
   ccache_top u_dut (.*);
   ccache_bus_model u_bus (.*);
   always #5 ref_clk_i = ~ref_clk_i;
   // Count bus cycles started; cut a hang short
   always @(posedge ref_clk_i) begin
      bus_q <= bus_req_o;
      if (bus_req_o && !bus_q)
         nbus <= nbus + 1;
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         end_sim();
      end
   end
   task automatic end_sim();
      if (miscompares == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   function automatic logic [31:0] pat(input logic [31:0] a);
      return {a[31:2], 2'b00} ^ 32'hc0de_0000;
   endfunction
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      @(posedge ref_clk_i);
      reg_wr_i    <= 1'b0;
   endtask
   task automatic reg_chk(input logic [7:0] a, input logic [31:0] ed);
      @(posedge ref_clk_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge ref_clk_i);
      reg_rd_i   <= 1'b0;
      #1;
      cmp("reg_rdata", ed, reg_rdata_o);
   endtask
   // One core access: checks read data, error flag and bus cycles started
   task automatic acc(input logic ins, we, input logic [31:0] a, input logic [2:0] fc,
                      input logic [31:0] wd, ed, input int eb);
      int n0;
      int i;
      n0 = nbus;
      i = 0;
      @(posedge ref_clk_i);
      core_req_i   <= 1'b1;
      core_instr_i <= ins;
      core_we_i    <= we;
      core_addr_i  <= a;
      core_fc_i    <= fc;
      core_wdata_i <= wd;
      do begin
         @(posedge ref_clk_i);
         #1;
         i++;
      end while (core_ack_o !== 1'b1 && i < 100);
      if (!we && !err_en)
         cmp("core_rdata", ed, core_rdata_o);
      cmp("core_err", {31'h0, err_en}, {31'h0, core_err_o});
      @(posedge ref_clk_i);
      core_req_i <= 1'b0;
      cmp("bus_cycles", eb, nbus - n0);
   endtask
   task automatic t_reset();
      reg_chk(ccache_pkg::REG_CTRL, 32'h0);
      reg_chk(ccache_pkg::REG_STAT, 32'h0);
      reg_chk(8'h0c, 32'h0);
   endtask
   task automatic t_ifill();
      burst_en <= 1'b1;
      acc(1'b1, 1'b0, 32'h100, 3'h6, 32'h0, pat(32'h100), 1);
      for (int k = 1; k < 4; k++)
         acc(1'b1, 1'b0, 32'h100 | 32'(k << 2), 3'h6, 32'h0, pat(32'h100 | 32'(k << 2)), 0);
      acc(1'b1, 1'b0, 32'h1f8, 3'h6, 32'h0, pat(32'h1f8), 1);
      acc(1'b1, 1'b0, 32'h1f0, 3'h6, 32'h0, pat(32'h1f0), 0);
      acc(1'b1, 1'b0, 32'h1100, 3'h6, 32'h0, pat(32'h1100), 1);
      acc(1'b1, 1'b0, 32'h100, 3'h6, 32'h0, pat(32'h100), 1);
   endtask
   task automatic t_space();
      acc(1'b1, 1'b0, 32'h104, 3'h7, 32'h0, pat(32'h104), 0);
      acc(1'b1, 1'b0, 32'h104, 3'h2, 32'h0, pat(32'h104), 1);
      acc(1'b0, 1'b0, 32'h200, 3'h5, 32'h0, pat(32'h200), 1);
      acc(1'b0, 1'b0, 32'h204, 3'h5, 32'h0, pat(32'h204), 0);
      acc(1'b0, 1'b0, 32'h204, 3'h6, 32'h0, pat(32'h204), 1);
   endtask
   task automatic t_partial();
      burst_en <= 1'b0;
      acc(1'b1, 1'b0, 32'h304, 3'h6, 32'h0, pat(32'h304), 1);
      acc(1'b1, 1'b0, 32'h304, 3'h6, 32'h0, pat(32'h304), 0);
      acc(1'b1, 1'b0, 32'h308, 3'h6, 32'h0, pat(32'h308), 1);
      acc(1'b1, 1'b0, 32'h300, 3'h6, 32'h0, pat(32'h300), 1);
   endtask
   task automatic t_abort();
      burst_en <= 1'b1;
      inh_en   <= 1'b1;
      acc(1'b1, 1'b0, 32'h400, 3'h6, 32'h0, pat(32'h400), 1);
      inh_en   <= 1'b0;
      acc(1'b1, 1'b0, 32'h404, 3'h6, 32'h0, pat(32'h404), 1);
      err_en   <= 1'b1;
      acc(1'b0, 1'b0, 32'h600, 3'h5, 32'h0, 32'h0, 1);
      err_en   <= 1'b0;
      acc(1'b0, 1'b0, 32'h600, 3'h5, 32'h0, pat(32'h600), 1);
   endtask
   task automatic t_write();
      acc(1'b0, 1'b0, 32'h700, 3'h5, 32'h0, pat(32'h700), 1);
      acc(1'b0, 1'b1, 32'h704, 3'h5, 32'h1234_5678, 32'h0, 1);
      acc(1'b0, 1'b0, 32'h704, 3'h5, 32'h0, 32'h1234_5678, 0);
      acc(1'b0, 1'b1, 32'h804, 3'h5, 32'h0bad_f00d, 32'h0, 1);
      acc(1'b0, 1'b0, 32'h804, 3'h5, 32'h0, pat(32'h804), 1);
      reg_wr(ccache_pkg::REG_CTRL, EN | (32'h1 << ccache_pkg::CTL_WA));
      acc(1'b0, 1'b1, 32'h904, 3'h5, 32'h5a5a_a5a5, 32'h0, 1);
      acc(1'b0, 1'b0, 32'h904, 3'h5, 32'h0, 32'h5a5a_a5a5, 0);
   endtask
   task automatic t_clear();
      acc(1'b1, 1'b0, 32'ha00, 3'h6, 32'h0, pat(32'ha00), 1);
      reg_wr(ccache_pkg::REG_ENTRY, 32'ha04);
      reg_wr(ccache_pkg::REG_CTRL, EN | (32'h1 << ccache_pkg::CTL_IENT));
      acc(1'b1, 1'b0, 32'ha08, 3'h6, 32'h0, pat(32'ha08), 0);
      acc(1'b1, 1'b0, 32'ha04, 3'h6, 32'h0, pat(32'ha04), 1);
      reg_wr(ccache_pkg::REG_CTRL, EN | (32'h1 << ccache_pkg::CTL_ICLR));
      acc(1'b1, 1'b0, 32'ha08, 3'h6, 32'h0, pat(32'ha08), 1);
      // Data side: entry clear on the allocated word, then clear all
      reg_wr(ccache_pkg::REG_ENTRY, 32'h904);
      reg_wr(ccache_pkg::REG_CTRL, EN | (32'h1 << ccache_pkg::CTL_DENT));
      acc(1'b0, 1'b0, 32'h904, 3'h5, 32'h0, pat(32'h904), 1);
      acc(1'b0, 1'b0, 32'h908, 3'h5, 32'h0, pat(32'h908), 0);
      reg_wr(ccache_pkg::REG_CTRL, EN | (32'h1 << ccache_pkg::CTL_DCLR));
      acc(1'b0, 1'b0, 32'h908, 3'h5, 32'h0, pat(32'h908), 1);
   endtask
   task automatic t_disable();
      @(posedge ref_clk_i);
      cache_disable_input_i <= 1'b1;
      repeat (4) @(posedge ref_clk_i);
      reg_chk(ccache_pkg::REG_STAT, 32'h1 << ccache_pkg::STA_DIS);
      acc(1'b1, 1'b0, 32'ha0c, 3'h6, 32'h0, pat(32'ha0c), 1);
      cache_disable_input_i <= 1'b0;
      reg_wr(ccache_pkg::REG_CTRL, 32'h0);
      acc(1'b1, 1'b0, 32'ha0c, 3'h6, 32'h0, pat(32'ha0c), 1);
   endtask
   initial begin
      {ref_clk_i, sys_rst_i} = 2'b01;
      {reg_wr_i, reg_rd_i, core_req_i, core_instr_i, core_we_i, reg_addr_i, reg_wdata_i,
       core_fc_i, core_addr_i, core_wdata_i, cache_disable_input_i, burst_en, err_en,
       inh_en, bus_q, miscompares, total_checks, nbus, cycles} = '0;
      repeat (6) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      t_reset();
      reg_wr(ccache_pkg::REG_CTRL, EN);
      t_ifill();
      t_space();
      t_partial();
      t_abort();
      t_write();
      t_clear();
      t_disable();
      end_sim();
   end
endmodule
